// ---- alarm_flag_id_reset_cal_regs.sv ----
// Sticky alarm flags, identity registers and reset/calibration control
//
// How it works
// - Input-2 signal loss sets sticky flag
// - Input-1 signal loss sets sticky flag
// - Reference signal loss sets sticky flag
// - Input-2 frequency offset sets sticky flag
// - Input-1 frequency offset sets sticky flag
// - Lock loss sets sticky flag
// - Unmasked flag drives interrupt when enabled
// - Writing zero clears a sticky flag
// - Part number and revision read only
// - Reset bit resets logic, disables outputs
// - Calibration bit starts calibration, self-clears
// - Lock-loss alarm drops when calibration ends
// - Setting changes need a new calibration
// - Control register reads zero after reset
// - Live signal-loss bits show monitor state
// - Live frequency-offset bits show alarm state
// - Live lock-loss bit shows lock state
`timescale 1ns/1ns
`include "alarm_bank_regs.svh"
module alarm_flag_id_reset_cal_regs #(
  parameter logic [11:0] PART_NUMBER     = 12'h123,  // Arbitrary value
  parameter logic [3:0]  REVISION        = 4'h1,     // Arbitrary value
  parameter int          SOFT_RST_CYCLES =
    (`SOFT_RST_TIME_MS * (`CORE_CLK_HZ / `MS_PER_S))
) (
  input  wire logic                      CORE_CLK_IN,
  input  wire logic                      RESETN_IN,
  input  wire alarm_types_pkg::reg_byte_t REG_ADDR_IN,
  input  wire alarm_types_pkg::reg_byte_t REG_WDATA_IN,
  input  wire logic                      REG_WR_IN,
  input  wire logic                      REG_RD_IN,
  output alarm_types_pkg::reg_byte_t     REG_RDATA_OUT,
  input  wire logic                      INPUT2_SIGLOSS_LIVE_IN,
  input  wire logic                      INPUT1_SIGLOSS_LIVE_IN,
  input  wire logic                      REFCLK_SIGLOSS_LIVE_IN,
  input  wire logic                      INPUT2_FREQ_OFFSET_LIVE_IN,
  input  wire logic                      INPUT1_FREQ_OFFSET_LIVE_IN,
  input  wire logic                      LOCK_LOSS_LIVE_IN,
  input  wire logic                      INPUT2_SIGLOSS_MASK_IN,
  input  wire logic                      INPUT1_SIGLOSS_MASK_IN,
  input  wire logic                      REFCLK_SIGLOSS_MASK_IN,
  input  wire logic                      INPUT2_FREQ_OFFSET_MASK_IN,
  input  wire logic                      INPUT1_FREQ_OFFSET_MASK_IN,
  input  wire logic                      LOCK_LOSS_MASK_IN,
  input  wire logic                      IRQ_PIN_EN_IN,
  input  wire logic                      CAL_DONE_IN,
  output logic                           IRQ_OUT,
  output logic                           LOCK_LOSS_ALARM_OUT,
  output logic                           CAL_START_OUT,
  output logic                           SOFT_RESET_OUT,
  output logic                           CLK_OUT_DISABLE_OUT
);
  import alarm_types_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Address match, used by every write and read decode
  function automatic logic hit(input reg_byte_t addr, input reg_byte_t ofs);
    hit = (addr == ofs);
  endfunction : hit

  localparam ctl_state_s CTL_RESET = '{
    rdata:     `REG_RESET_VALUE,
    cal_state: CAL_IDLE,
    cal_pulse: 1'b0,
    lol_alarm: 1'b0,
    irq:       1'b0
  };

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  ctl_state_s             st_reg;      // Registered state
  ctl_state_s             st_next;     // Next state
  logic [`FLAG_CNT-1:0]   live_vec;    // Live alarms, flag order
  logic [`FLAG_CNT-1:0]   mask_vec;    // Masks, flag order
  logic [`FLAG_CNT-1:0]   clr_vec;     // Host clear strobes
  logic [`FLAG_CNT-1:0]   flags;       // Sticky flags
  logic                   soft_active; // Software reset in progress
  logic                   sig_wr;      // Write to signal-loss flags
  logic                   lock_wr;     // Write to offset/lock flags
  logic                   ctl_wr;      // Write to control register
  logic                   soft_start;  // Request to begin soft reset
  logic                   cal_req;     // Request to begin calibration
  reg_byte_t              rd_byte;     // Read mux output

  // ------------------------------------------------------------
  // Flag ordering: [2:0] signal loss, [5:3] lock and offsets
  // ------------------------------------------------------------

  // Lock loss uses the shown alarm so calibration counts as unlocked
  assign live_vec = {INPUT2_FREQ_OFFSET_LIVE_IN,
                     INPUT1_FREQ_OFFSET_LIVE_IN,
                     st_reg.lol_alarm,
                     INPUT2_SIGLOSS_LIVE_IN,
                     INPUT1_SIGLOSS_LIVE_IN,
                     REFCLK_SIGLOSS_LIVE_IN};

  assign mask_vec = {INPUT2_FREQ_OFFSET_MASK_IN,
                     INPUT1_FREQ_OFFSET_MASK_IN,
                     LOCK_LOSS_MASK_IN,
                     INPUT2_SIGLOSS_MASK_IN,
                     INPUT1_SIGLOSS_MASK_IN,
                     REFCLK_SIGLOSS_MASK_IN};

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------

  // Only a zero written to a flag bit clears it; ones do nothing
  assign sig_wr  = REG_WR_IN && hit(REG_ADDR_IN, `OFS_SIG_STICKY);
  assign lock_wr = REG_WR_IN && hit(REG_ADDR_IN, `OFS_LOCK_STICKY);
  assign ctl_wr  = REG_WR_IN && hit(REG_ADDR_IN, `OFS_CTRL);

  assign clr_vec[`SIG_FLAG_CNT-1:0] =
    {`SIG_FLAG_CNT{sig_wr}} & ~REG_WDATA_IN[`SIG_FLAG_LSB +: `SIG_FLAG_CNT];
  assign clr_vec[`FLAG_CNT-1:`SIG_FLAG_CNT] =
    {`LOCK_FLAG_CNT{lock_wr}} & ~REG_WDATA_IN[`LOCK_FLAG_LSB +: `LOCK_FLAG_CNT];

  // A reset request wins over a calibration request in the same write
  assign soft_start = ctl_wr && REG_WDATA_IN[`CTRL_SOFT_RST_BIT] && !soft_active;
  assign cal_req    = ctl_wr && REG_WDATA_IN[`CTRL_CAL_BIT]
                      && !REG_WDATA_IN[`CTRL_SOFT_RST_BIT] && !soft_active;

  // ------------------------------------------------------------
  // Sticky flags and software reset timer
  // ------------------------------------------------------------

  // Set beats clear inside the bank, so a still-active alarm stays flagged
  sticky_flag_bank #(
    .W (`FLAG_CNT)
  ) u_flags (
    .clk_in    (CORE_CLK_IN),
    .resetn_in (RESETN_IN),
    .set_in    (live_vec),
    .clr_in    (clr_vec),
    .flush_in  (soft_active),
    .flags_out (flags)
  );

  // Host must stay off the port while this runs; the timer just models it
  soft_reset_stretcher #(
    .CYCLES (SOFT_RST_CYCLES)
  ) u_soft_rst (
    .clk_in     (CORE_CLK_IN),
    .resetn_in  (RESETN_IN),
    .start_in   (soft_start),
    .active_out (soft_active)
  );

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    rd_byte = `REG_RESET_VALUE;

    // Read mux; reserved bits and unmapped offsets read zero
    unique case (1'b1)
      hit(REG_ADDR_IN, `OFS_LIVE_SIG): begin
        rd_byte[`SIG_FLAG_LSB +: `SIG_FLAG_CNT] = live_vec[`SIG_FLAG_CNT-1:0];
      end
      hit(REG_ADDR_IN, `OFS_LIVE_LOCK): begin
        rd_byte[`LIVE_FLAG_LSB +: `LOCK_FLAG_CNT] = live_vec[`FLAG_CNT-1:`SIG_FLAG_CNT];
      end
      hit(REG_ADDR_IN, `OFS_SIG_STICKY): begin
        rd_byte[`SIG_FLAG_LSB +: `SIG_FLAG_CNT] = flags[`SIG_FLAG_CNT-1:0];
      end
      hit(REG_ADDR_IN, `OFS_LOCK_STICKY): begin
        rd_byte[`LOCK_FLAG_LSB +: `LOCK_FLAG_CNT] = flags[`FLAG_CNT-1:`SIG_FLAG_CNT];
      end
      hit(REG_ADDR_IN, `OFS_PART_HIGH): begin
        rd_byte = PART_NUMBER[`PART_HIGH_MSB:`PART_HIGH_LSB];
      end
      hit(REG_ADDR_IN, `OFS_PART_LOW): begin
        rd_byte = {PART_NUMBER[`PART_LOW_MSB:`PART_LOW_LSB], REVISION};
      end
      hit(REG_ADDR_IN, `OFS_CTRL): begin
        rd_byte[`CTRL_SOFT_RST_BIT] = soft_active;
        rd_byte[`CTRL_CAL_BIT]      = st_reg.cal_pulse;
      end
      default: begin
        rd_byte = `REG_RESET_VALUE;
      end
    endcase

    // Read data is held until the next read strobe or a software reset
    if (REG_RD_IN) begin
      st_next.rdata = rd_byte;
    end

    // Start bit lives one cycle only, so the host reads it back zero unless its read strobe falls in the cycle right after the write
    st_next.cal_pulse = cal_req;

    // Calibration tracker; a fresh request restarts it
    unique case (st_reg.cal_state)
      CAL_IDLE: begin
        if (cal_req) begin
          st_next.cal_state = CAL_BUSY;
        end
      end
      CAL_BUSY: begin
        if (CAL_DONE_IN && !cal_req) begin
          st_next.cal_state = CAL_IDLE;
        end
      end
    endcase

    // Alarm stays high while calibrating, falls once it finishes and locks
    st_next.lol_alarm = LOCK_LOSS_LIVE_IN || (st_next.cal_state == CAL_BUSY);

    // Interrupt level lags the flags by one cycle
    st_next.irq = IRQ_PIN_EN_IN && |(flags & ~mask_vec);

    // Software reset returns all control state to its reset values
    if (soft_active) begin
      st_next = CTL_RESET;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_reg <= CTL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign REG_RDATA_OUT       = st_reg.rdata;
  assign IRQ_OUT             = st_reg.irq;
  assign LOCK_LOSS_ALARM_OUT = st_reg.lol_alarm;
  assign CAL_START_OUT       = st_reg.cal_pulse;
  assign SOFT_RESET_OUT      = soft_active;
  assign CLK_OUT_DISABLE_OUT = soft_active;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  // Flags: each live alarm sets its flag on the next edge
  a_in2_sig_set: assert property (
    INPUT2_SIGLOSS_LIVE_IN && !soft_active |=> flags[2])
    else $error("input-2 signal-loss flag did not set");
  a_in1_sig_set: assert property (
    INPUT1_SIGLOSS_LIVE_IN && !soft_active |=> flags[1])
    else $error("input-1 signal-loss flag did not set");
  a_in1_sig_hold: assert property (
    flags[1] && !clr_vec[1] && !soft_active |=> flags[1])
    else $error("input-1 signal-loss flag dropped without a clear");
  a_ref_sig_set: assert property (
    REFCLK_SIGLOSS_LIVE_IN && !soft_active |=> flags[0])
    else $error("reference signal-loss flag did not set");
  a_in2_fos_set: assert property (
    INPUT2_FREQ_OFFSET_LIVE_IN && !soft_active |=> flags[5])
    else $error("input-2 frequency flag did not set");
  a_in1_fos_set: assert property (
    INPUT1_FREQ_OFFSET_LIVE_IN && !soft_active |=> flags[4])
    else $error("input-1 frequency flag did not set");
  a_lock_flag_set: assert property (
    LOCK_LOSS_ALARM_OUT && !soft_active |=> flags[3])
    else $error("lock-loss flag did not set");

  // Interrupt: one cycle behind the enabled, unmasked flags
  a_irq_follow: assert property (
    IRQ_PIN_EN_IN && |(flags & ~mask_vec) && !soft_active |=> IRQ_OUT)
    else $error("interrupt not raised for unmasked flag");
  a_irq_gated: assert property (!IRQ_PIN_EN_IN |=> !IRQ_OUT)
    else $error("interrupt raised while pin disabled");
  a_irq_clear: assert property (
    !(IRQ_PIN_EN_IN && |(flags & ~mask_vec)) |=> !IRQ_OUT)
    else $error("interrupt raised with no unmasked flag");

  // Host writes: zero clears a quiet flag, reserved bits stay zero
  a_flag_clear: assert property (
    sig_wr && !REG_WDATA_IN[0] && !REFCLK_SIGLOSS_LIVE_IN |=> !flags[0])
    else $error("write of zero did not clear flag");
  a_res_bits: assert property (
    REG_RD_IN && hit(REG_ADDR_IN, `OFS_LOCK_STICKY) |=>
      REG_RDATA_OUT[0] == 1'b0 && REG_RDATA_OUT[7:4] == 4'h0)
    else $error("reserved bits of offset and lock flags not zero");

  // Identity bytes are constants, whatever the host wrote
  a_part_high: assert property (
    REG_RD_IN && hit(REG_ADDR_IN, `OFS_PART_HIGH) && !soft_active |=>
      REG_RDATA_OUT == PART_NUMBER[`PART_HIGH_MSB:`PART_HIGH_LSB])
    else $error("upper part number read back wrong");
  a_part_read: assert property (
    REG_RD_IN && hit(REG_ADDR_IN, `OFS_PART_LOW) |=>
      REG_RDATA_OUT == {PART_NUMBER[`PART_LOW_MSB:`PART_LOW_LSB], REVISION})
    else $error("part number or revision read back wrong");

  // Software reset: outputs off, flags flushed, calibration suppressed
  a_soft_reset: assert property (
    soft_start |=> SOFT_RESET_OUT && CLK_OUT_DISABLE_OUT ##1 !CAL_START_OUT)
    else $error("software reset did not take effect");
  a_soft_flush: assert property (
    soft_active |=> flags == '0)
    else $error("flags not flushed during software reset");
  a_reset_wins: assert property (
    ctl_wr && REG_WDATA_IN[`CTRL_SOFT_RST_BIT] && !soft_active |=> !CAL_START_OUT)
    else $error("calibration started by a reset write");

  // Calibration: one start pulse, alarm high until the engine is done
  a_cal_pulse: assert property (cal_req |=> CAL_START_OUT ##1 !CAL_START_OUT)
    else $error("calibration start did not self-clear");
  a_cal_alarm: assert property (
    st_reg.cal_state == CAL_BUSY |-> LOCK_LOSS_ALARM_OUT)
    else $error("lock-loss alarm low during calibration");
  a_cal_finish: assert property (
    st_reg.cal_state == CAL_BUSY && CAL_DONE_IN && !cal_req && !LOCK_LOSS_LIVE_IN
      && !soft_active |=> !LOCK_LOSS_ALARM_OUT)
    else $error("lock-loss alarm stuck after calibration");
  a_ctrl_read: assert property (
    REG_RD_IN && hit(REG_ADDR_IN, `OFS_CTRL) && !soft_active && !st_reg.cal_pulse
      |=> REG_RDATA_OUT == `REG_RESET_VALUE)
    else $error("control register read not zero");
  a_live_read: assert property (
    REG_RD_IN && hit(REG_ADDR_IN, `OFS_LIVE_LOCK) && !soft_active |=>
      REG_RDATA_OUT[0] == $past(st_reg.lol_alarm))
    else $error("live lock-loss bit read back wrong");

  // Main scenarios
  c_flag_cycle: cover property (flags[2] ##1 sig_wr ##1 !flags[2]);
  c_rearm:      cover property (sig_wr && INPUT2_SIGLOSS_LIVE_IN ##1 flags[2]);
  c_cal_done:   cover property (CAL_START_OUT ##[1:20] !LOCK_LOSS_ALARM_OUT);
  c_soft_rst:   cover property ($fell(SOFT_RESET_OUT));
  c_irq:        cover property ($rose(IRQ_OUT));

endmodule : alarm_flag_id_reset_cal_regs

// ---- alarm_bank_regs.svh ----
// Offsets, field positions, reset values and timing figures of the alarm register slice
`ifndef ALARM_BANK_REGS_SVH
`define ALARM_BANK_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_LIVE_SIG     8'h81
`define OFS_LIVE_LOCK    8'h82
`define OFS_SIG_STICKY   8'h83
`define OFS_LOCK_STICKY  8'h84
`define OFS_PART_HIGH    8'h86
`define OFS_PART_LOW     8'h87
`define OFS_CTRL         8'h88

// ------------------------------------------------------------
// Field positions and widths
// ------------------------------------------------------------
`define SIG_FLAG_LSB     0
`define SIG_FLAG_CNT     3
`define LOCK_FLAG_LSB    1
`define LOCK_FLAG_CNT    3
`define FLAG_CNT         6
`define CTRL_SOFT_RST_BIT 7
`define CTRL_CAL_BIT     6
`define PART_HIGH_MSB    11
`define PART_HIGH_LSB    4
`define PART_LOW_MSB     3
`define PART_LOW_LSB     0
`define LIVE_FLAG_LSB    0

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define REG_RESET_VALUE  8'h00
`define FLAG_RESET_VALUE 6'h00
`define SOFT_RST_TIME_MS 10
`define CORE_CLK_HZ      100000000
`define MS_PER_S         1000

`endif

// ---- alarm_types_pkg.sv ----
// Shared types of the alarm register slice
package alarm_types_pkg;

  // One register byte on the internal register port
  typedef logic [7:0] reg_byte_t;

  // Calibration tracker
  typedef enum logic {
    CAL_IDLE = 1'b0,
    CAL_BUSY = 1'b1
  } cal_state_e;

  // Whole state of the top module
  typedef struct packed {
    reg_byte_t  rdata;      // Read data held for the host
    cal_state_e cal_state;  // Calibration in progress or not
    logic       cal_pulse;  // Self-clearing calibration start
    logic       lol_alarm;  // Lock-loss alarm as shown to the outside
    logic       irq;        // Interrupt level
  } ctl_state_s;

endpackage : alarm_types_pkg

// ---- sticky_flag_bank.sv ----
// Bank of sticky alarm flags: set by live alarms, cleared by host writes of zero
`timescale 1ns/1ns
module sticky_flag_bank #(
  parameter int W = 6
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] set_in,    // Live alarm levels
  input  wire logic [W-1:0] clr_in,    // Host clear strobes
  input  wire logic         flush_in,  // Soft reset clears everything
  output logic      [W-1:0] flags_out
);
  import alarm_types_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] flags;
  } flag_state_s;

  flag_state_s st_reg;
  flag_state_s st_next;

  // Per-bit update; set beats clear so no alarm edge is lost
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < W; i++) begin
      st_next.flags[i] = set_in[i] | (st_reg.flags[i] & ~clr_in[i]);
    end
    // Soft reset overrides, live alarms re-set flags afterwards
    if (flush_in) begin
      st_next.flags = '0;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg.flags <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags_out = st_reg.flags;

endmodule : sticky_flag_bank

// ---- soft_reset_stretcher.sv ----
// Holds the software reset active for a fixed number of cycles
`timescale 1ns/1ns
module soft_reset_stretcher #(
  parameter int CYCLES = 1000000
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic start_in,   // One-cycle request
  output logic      active_out  // High for CYCLES cycles
);
  import alarm_types_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic          active;
    logic [CW-1:0] cnt;
  } stretch_state_s;

  stretch_state_s st_reg;
  stretch_state_s st_next;

  // Count down; a request while active is ignored
  always_comb begin
    st_next = st_reg;
    if (!st_reg.active) begin
      if (start_in) begin
        st_next.active = 1'b1;
        st_next.cnt    = LAST;
      end
    end else if (st_reg.cnt == '0) begin
      st_next.active = 1'b0;
    end else begin
      st_next.cnt = st_reg.cnt - CW'(1);
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign active_out = st_reg.active;

endmodule : soft_reset_stretcher

// ---- reg_host_model.sv ----
// Host-side model driving the register port of the alarm slice
`timescale 1ns/1ns
module reg_host_model #(
  parameter int SETTLE = 20
) (
  input  wire logic                       clk_in,
  output alarm_types_pkg::reg_byte_t      addr_out,
  output alarm_types_pkg::reg_byte_t      wdata_out,
  output logic                            wr_out,
  output logic                            rd_out,
  input  wire alarm_types_pkg::reg_byte_t rdata_in
);
  import alarm_types_pkg::*;
  // ----------------------------------------
  // Bus access tasks
  // ----------------------------------------
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Released address and data go inverted so stale values never pass
  task automatic write_reg(input reg_byte_t a, input reg_byte_t d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : write_reg
  // Read data is taken once the registered answer has landed
  task automatic read_reg(input reg_byte_t a, output reg_byte_t d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask : read_reg
  // No access at all while the software reset runs
  task automatic settle();
    repeat (SETTLE) @(posedge clk_in);
  endtask : settle
  // Clock is assumed stable; run after any setting change
  task automatic calibrate();
    write_reg(8'h88, 8'h40);
  endtask : calibrate
endmodule : reg_host_model

// ---- alarm_flag_id_reset_cal_regs_tb.sv ----
// Self-checking bench of the alarm register slice
`timescale 1ns/1ns
`include "alarm_bank_regs.svh"
module alarm_flag_id_reset_cal_regs_tb;
  import alarm_types_pkg::*;
  // ----------------------------------------
  // Settings and signals
  // ----------------------------------------
  localparam int RST_CYC = 16;
  localparam logic [11:0] PN = 12'h5A7; // Arbitrary value
  localparam logic [3:0] RV = 4'h3;     // Arbitrary value
  logic clk, resetn, wr, rd, en, cal_done, irq, lock_loss_alarm, cal_start, soft_rst, clk_dis;
  reg_byte_t addr, wdata, rdata, rd_val;
  logic [5:0] live, mask; // [0]ref [1]in1 [2]in2 [3]lock [4]in1 fos [5]in2 fos
  int errors, comparisons, flags_m, n;

  alarm_flag_id_reset_cal_regs #(.PART_NUMBER(PN), .REVISION(RV),
    .SOFT_RST_CYCLES(RST_CYC)) dut (
    .CORE_CLK_IN(clk), .RESETN_IN(resetn), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .INPUT2_SIGLOSS_LIVE_IN(live[2]), .INPUT1_SIGLOSS_LIVE_IN(live[1]),
    .REFCLK_SIGLOSS_LIVE_IN(live[0]), .INPUT2_FREQ_OFFSET_LIVE_IN(live[5]),
    .INPUT1_FREQ_OFFSET_LIVE_IN(live[4]), .LOCK_LOSS_LIVE_IN(live[3]),
    .INPUT2_SIGLOSS_MASK_IN(mask[2]), .INPUT1_SIGLOSS_MASK_IN(mask[1]),
    .REFCLK_SIGLOSS_MASK_IN(mask[0]), .INPUT2_FREQ_OFFSET_MASK_IN(mask[5]),
    .INPUT1_FREQ_OFFSET_MASK_IN(mask[4]), .LOCK_LOSS_MASK_IN(mask[3]),
    .IRQ_PIN_EN_IN(en), .CAL_DONE_IN(cal_done), .IRQ_OUT(irq),
    .LOCK_LOSS_ALARM_OUT(lock_loss_alarm), .CAL_START_OUT(cal_start),
    .SOFT_RESET_OUT(soft_rst), .CLK_OUT_DISABLE_OUT(clk_dis));

  reg_host_model #(.SETTLE(RST_CYC + 4)) host (.clk_in(clk), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));

  always #5 clk = ~clk;

  // ----------------------------------------
  // Compare, model and closing tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rd_chk(input reg_byte_t a, input reg_byte_t exp, input string what);
    host.read_reg(a, rd_val);
    check(what, exp, rd_val);
  endtask : rd_chk
  // Model flags against both sticky bytes, then the interrupt level
  task automatic flags_chk();
    rd_chk(`OFS_SIG_STICKY, {5'h00, 3'(flags_m)}, "sig sticky");
    rd_chk(`OFS_LOCK_STICKY, {4'h0, 3'(flags_m >> 3), 1'b0}, "lock sticky");
    check("irq", {7'h00, en & (|(6'(flags_m) & ~mask))}, {7'h00, irq});
  endtask : flags_chk
  // One-cycle live alarm; the sticky copy must outlast it
  task automatic pulse(input logic [5:0] v);
    @(posedge clk);
    live <= v;
    @(posedge clk);
    live <= 6'h00;
    repeat (3) @(posedge clk);
    flags_m = flags_m | int'(v);
  endtask : pulse
  // Zero clears every flag; a still-active alarm sets it again
  task automatic clear_all();
    host.write_reg(`OFS_SIG_STICKY, 8'h00);
    host.write_reg(`OFS_LOCK_STICKY, 8'h00);
    flags_m = int'(live);
  endtask : clear_all
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Watchdog: the tests need about 700 cycles
  // ----------------------------------------
  initial begin
    #200000;
    errors++;
    conclude();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    live = 6'h00;
    mask = 6'h00;
    en = 1'b1;
    cal_done = 1'b0;
    errors = 0;
    comparisons = 0;
    flags_m = 0;
    rd_val = 8'($urandom(32'h83CB));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // Identity, reset values, read-only and unmapped places
    rd_chk(`OFS_CTRL, 8'h00, "ctrl");
    host.write_reg(`OFS_PART_HIGH, 8'hFF);
    host.write_reg(`OFS_PART_LOW, 8'h00);
    rd_chk(`OFS_PART_HIGH, PN[11:4], "part high");
    rd_chk(`OFS_PART_LOW, {PN[3:0], RV}, "part low");
    rd_chk(8'h85, 8'h00, "unmapped");
    flags_chk();
    $display("test identity done");
    // Each source alone: set, interrupt, mask, clear
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      mask <= ~(6'h01 << i);
      pulse(6'h01 << i);
      flags_chk();
      @(posedge clk);
      mask <= 6'h3F;
      repeat (2) @(posedge clk);
      #1;
      check("irq masked", 8'h00, {7'h00, irq});
      clear_all();
      flags_chk();
    end
    $display("test sources done");
    // Live bytes follow held alarms; clear under active alarm
    @(posedge clk);
    live <= 6'h3F;
    repeat (4) @(posedge clk);
    rd_chk(`OFS_LIVE_SIG, 8'h07, "live sig");
    rd_chk(`OFS_LIVE_LOCK, 8'h07, "live lock");
    clear_all();
    flags_chk();
    @(posedge clk);
    live <= 6'h00;
    repeat (4) @(posedge clk);
    rd_chk(`OFS_LIVE_SIG, 8'h00, "live sig idle");
    rd_chk(`OFS_LIVE_LOCK, 8'h00, "live lock idle");
    clear_all();
    flags_chk();
    $display("test live done");
    // Random alarms, masks and pin enable
    for (int k = 0; k < 24; k++) begin
      @(posedge clk);
      mask <= 6'($urandom);
      en <= 1'($urandom);
      pulse(6'($urandom));
      flags_chk();
      clear_all();
    end
    flags_chk();
    $display("test random done");
    // Calibration: one start pulse, alarm until done, bit self-clears
    host.calibrate();
    #1;
    check("cal start", 8'h01, {7'h00, cal_start});
    check("alarm busy", 8'h01, {7'h00, lock_loss_alarm});
    @(posedge clk);
    #1;
    check("cal start once", 8'h00, {7'h00, cal_start});
    rd_chk(`OFS_CTRL, 8'h00, "ctrl self clear");
    check("alarm held", 8'h01, {7'h00, lock_loss_alarm});
    flags_m = flags_m | 8;
    @(posedge clk);
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("alarm done", 8'h00, {7'h00, lock_loss_alarm});
    flags_chk();
    clear_all();
    $display("test calibration done");
    // Software reset: exact length, outputs disabled, flags flushed
    pulse(6'h07);
    host.write_reg(`OFS_CTRL, 8'h80);
    #1;
    n = 0;
    while (soft_rst === 1'b1 && n < 40) begin
      check("clk disable", 8'h01, {7'h00, clk_dis});
      n++;
      @(posedge clk);
      #1;
    end
    check("reset length", 8'(RST_CYC), 8'(n));
    host.settle();
    flags_m = 0;
    flags_chk();
    rd_chk(`OFS_CTRL, 8'h00, "ctrl after reset");
    $display("test soft reset done");
    conclude();
  end
endmodule : alarm_flag_id_reset_cal_regs_tb
